/* File: hdl/hqr_queue_pair.sv */
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - Submitter writes at tail, then increments tail
// - Tail wraps to slot zero after last
// - Consumer takes head entry, increments, wraps
// - Submit only while queue not full
// - Consume only while queue not empty
// - Invalid doorbell posts async event if armed
// - Errored submission queue: no further consumption
// - Completion tail hidden; report submission head
// - Tail write submits one or more entries
// - Posted entry carries inverted phase bit
// - Head write frees one or more slots
// - Full completion queue holds off posting
// - Empty when head equals tail
// - Full when head equals tail plus one
// - Size is 16-bit zero-based, minimum two
// - I/O up to cap, admin 4K
// - Each queue has 16-bit identifier
// - Priority ignored without urgent weighted arbitration
// - Tail doorbell overwrites stored tail
// - Head doorbell overwrites stored head
module hqr_queue_pair #(
    parameter logic [15:0] MAX_ENTRIES = hqr_pkg::IO_MAX_SIZE,
    parameter bit WRR_URGENT = 1'b0
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic sq_fetch_valid,
    output logic [15:0] sq_fetch_slot,
    input wire logic sq_fetch_ack,
    input wire logic cpl_valid,
    output logic cpl_ready,
    output hqr_pkg::hqr_cpl_post_s cq_post,
    output hqr_pkg::hqr_aer_post_s aer_post,
    output logic [1:0] sq_priority
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic sq_live;
        logic cq_live;
        logic [15:0] sq_size;
        logic [15:0] cq_size;
        logic [15:0] sq_id;
        logic [15:0] cq_id;
        logic [1:0] prio;
        logic [15:0] sq_tail;
        logic [15:0] sq_head;
        logic [15:0] cq_head;
        logic [15:0] cq_tail;
        logic cq_phase;
        logic sq_err;
        logic cq_err;
        logic cfg_err;
        logic aer_armed;
        logic fetch_valid;
        logic cpl_ready;
        hqr_pkg::hqr_cpl_post_s post;
        hqr_pkg::hqr_aer_post_s aer;
    } hqr_state_s;

    hqr_state_s st;
    hqr_state_s next_st;

    function automatic logic [15:0] ring_inc(input logic [15:0] p, input logic [15:0] size);
        ring_inc = (p == size) ? 16'h0000 : p + 16'h0001;
    endfunction

    // Distance from b forward to a around a ring of size+1 slots
    function automatic logic [15:0] ring_dist(input logic [15:0] a, input logic [15:0] b,
                                              input logic [15:0] size);
        logic [16:0] wide;
        wide = (a >= b) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, size} + 17'h0_0001 - {1'b0, b};
        ring_dist = wide[15:0];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nv[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    function automatic logic size_ok(input logic [15:0] size, input logic [15:0] qid);
        logic [15:0] cap;
        cap = MAX_ENTRIES;
        if (qid == hqr_pkg::ADMIN_QID && cap > hqr_pkg::ADMIN_MAX_SIZE) begin
            cap = hqr_pkg::ADMIN_MAX_SIZE;
        end
        size_ok = (size >= hqr_pkg::MIN_SIZE) && (size <= cap);
    endfunction

    logic req;
    logic wr;
    logic rd;
    logic sq_empty;
    logic sq_full;
    logic cq_empty;
    logic cq_full;
    logic [31:0] wmerged;
    logic [31:0] rmux;
    logic [15:0] sq_occ;
    logic [15:0] cq_occ;
    logic sq_db_ok;
    logic cq_db_ok;
    logic [31:0] size_sq_merged;
    logic [31:0] size_cq_merged;
    logic [31:0] qid_merged;

    always_comb begin
        req = wb_cyc && wb_stb && !st.ack;
        wr = req && wb_we;
        rd = req && !wb_we;
        sq_empty = (st.sq_head == st.sq_tail);
        cq_empty = (st.cq_head == st.cq_tail);
        sq_full = (st.sq_head == ring_inc(st.sq_tail, st.sq_size));
        cq_full = (st.cq_head == ring_inc(st.cq_tail, st.cq_size));
        sq_occ = ring_dist(st.sq_tail, st.sq_head, st.sq_size);
        cq_occ = ring_dist(st.cq_tail, st.cq_head, st.cq_size);
        wmerged = merge(32'h0000_0000, wb_dat_w, wb_sel);
        size_sq_merged = merge({16'h0000, st.sq_size}, wb_dat_w, wb_sel);
        size_cq_merged = merge({16'h0000, st.cq_size}, wb_dat_w, wb_sel);
        qid_merged = merge({st.cq_id, st.sq_id}, wb_dat_w, wb_sel);
        // New tail may add at most the free slots: size minus occupancy
        sq_db_ok = (wmerged[15:0] <= st.sq_size)
            && (ring_dist(wmerged[15:0], st.sq_tail, st.sq_size) <= st.sq_size - sq_occ);
        // New head may free only slots that hold posted entries
        cq_db_ok = (wmerged[15:0] <= st.cq_size)
            && (ring_dist(wmerged[15:0], st.cq_head, st.cq_size) <= cq_occ);
        rmux = 32'h0000_0000;
        case (wb_adr)
            hqr_pkg::OFS_QUEUE_CFG: begin
                rmux[hqr_pkg::CFG_CQ_LIVE] = st.cq_live;
                rmux[hqr_pkg::CFG_SQ_LIVE] = st.sq_live;
            end
            hqr_pkg::OFS_SQ_SIZE: rmux[15:0] = st.sq_size;
            hqr_pkg::OFS_CQ_SIZE: rmux[15:0] = st.cq_size;
            hqr_pkg::OFS_QUEUE_ID: rmux = {st.cq_id, st.sq_id};
            hqr_pkg::OFS_SQ_PRIO: rmux[1:0] = st.prio;
            hqr_pkg::OFS_STATUS: begin
                rmux[hqr_pkg::ST_SQ_EMPTY] = sq_empty;
                rmux[hqr_pkg::ST_SQ_FULL] = sq_full;
                rmux[hqr_pkg::ST_CQ_EMPTY] = cq_empty;
                rmux[hqr_pkg::ST_CQ_FULL] = cq_full;
                rmux[hqr_pkg::ST_SQ_DB_ERR] = st.sq_err;
                rmux[hqr_pkg::ST_CQ_DB_ERR] = st.cq_err;
                rmux[hqr_pkg::ST_AER_ARMED] = st.aer_armed;
                rmux[hqr_pkg::ST_CFG_ERR] = st.cfg_err;
                rmux[hqr_pkg::ST_SQ_LIVE] = st.sq_live;
                rmux[hqr_pkg::ST_CQ_LIVE] = st.cq_live;
            end
            // Completion tail is deliberately not mapped
            hqr_pkg::OFS_SQ_HEAD: rmux[15:0] = st.sq_head;
            hqr_pkg::OFS_CAP: rmux[15:0] = MAX_ENTRIES;
            default: rmux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.ack = req;
        next_st.post.valid = 1'b0;
        next_st.aer.valid = 1'b0;
        if (rd) begin
            next_st.rdata = rmux;
        end

        // Consumption from the submission ring
        if (st.fetch_valid && sq_fetch_ack) begin
            next_st.sq_head = ring_inc(st.sq_head, st.sq_size);
        end

        // Posting to the completion ring, stalled while full
        if (st.cpl_ready && cpl_valid) begin
            next_st.post.valid = 1'b1;
            next_st.post.slot = st.cq_tail;
            next_st.post.phase = st.cq_phase;
            next_st.post.sq_head_report_field = next_st.sq_head;
            next_st.post.sq_id = st.sq_id;
            next_st.cq_tail = ring_inc(st.cq_tail, st.cq_size);
            if (st.cq_tail == st.cq_size) begin
                next_st.cq_phase = !st.cq_phase;
            end
        end

        if (wr) begin
            case (wb_adr)
                hqr_pkg::OFS_QUEUE_CFG: begin
                    next_st.cfg_err = 1'b0;
                    if (wb_sel[0]) begin
                        // Refuse creating a submission queue unless its completion queue was live before this write
                        // and deleting a completion queue that still has one bound
                        if (wb_dat_w[hqr_pkg::CFG_SQ_LIVE] && !st.sq_live) begin
                            if (!st.cq_live || !size_ok(st.sq_size, st.sq_id)) begin
                                next_st.cfg_err = 1'b1;
                            end else begin
                                next_st.sq_live = 1'b1;
                                next_st.sq_head = hqr_pkg::RST_PTR;
                                next_st.sq_tail = hqr_pkg::RST_PTR;
                                next_st.sq_err = 1'b0;
                            end
                        end else if (!wb_dat_w[hqr_pkg::CFG_SQ_LIVE]) begin
                            next_st.sq_live = 1'b0;
                        end
                        if (wb_dat_w[hqr_pkg::CFG_CQ_LIVE] && !st.cq_live) begin
                            if (!size_ok(st.cq_size, st.cq_id)) begin
                                next_st.cfg_err = 1'b1;
                            end else begin
                                next_st.cq_live = 1'b1;
                                next_st.cq_head = hqr_pkg::RST_PTR;
                                next_st.cq_tail = hqr_pkg::RST_PTR;
                                next_st.cq_phase = hqr_pkg::RST_PHASE;
                                next_st.cq_err = 1'b0;
                            end
                        end else if (!wb_dat_w[hqr_pkg::CFG_CQ_LIVE] && st.cq_live) begin
                            if (st.sq_live && wb_dat_w[hqr_pkg::CFG_SQ_LIVE]) begin
                                next_st.cfg_err = 1'b1;
                            end else begin
                                next_st.cq_live = 1'b0;
                            end
                        end
                    end
                end
                hqr_pkg::OFS_SQ_SIZE: begin
                    if (!st.sq_live) begin
                        next_st.sq_size = size_sq_merged[15:0];
                    end
                end
                hqr_pkg::OFS_CQ_SIZE: begin
                    if (!st.cq_live) begin
                        next_st.cq_size = size_cq_merged[15:0];
                    end
                end
                hqr_pkg::OFS_QUEUE_ID: begin
                    if (!st.sq_live) begin
                        next_st.sq_id = qid_merged[15:0];
                    end
                    if (!st.cq_live) begin
                        next_st.cq_id = qid_merged[31:hqr_pkg::QID_CQ_LSB];
                    end
                end
                hqr_pkg::OFS_SQ_PRIO: begin
                    if (WRR_URGENT && wb_sel[0]) begin
                        next_st.prio = wb_dat_w[1:0];
                    end
                    // Without urgent weighted arbitration the setting is dropped
                end
                hqr_pkg::OFS_SQ_TAIL_DB: begin
                    if (st.sq_live && !st.sq_err) begin
                        if (sq_db_ok) begin
                            next_st.sq_tail = wmerged[15:0];
                        end else begin
                            next_st.sq_err = 1'b1;
                            if (st.aer_armed) begin
                                next_st.aer.valid = 1'b1;
                                next_st.aer.status = hqr_pkg::STATUS_INVALID_DB;
                                next_st.aer.qid = st.sq_id;
                                next_st.aer_armed = 1'b0;
                            end
                        end
                    end
                end
                hqr_pkg::OFS_CQ_HEAD_DB: begin
                    if (st.cq_live && !st.cq_err) begin
                        if (cq_db_ok) begin
                            next_st.cq_head = wmerged[15:0];
                        end else begin
                            next_st.cq_err = 1'b1;
                            if (st.aer_armed) begin
                                next_st.aer.valid = 1'b1;
                                next_st.aer.status = hqr_pkg::STATUS_INVALID_DB;
                                next_st.aer.qid = st.cq_id;
                                next_st.aer_armed = 1'b0;
                            end
                        end
                    end
                end
                hqr_pkg::OFS_AER_ARM: begin
                    // Arming in the cycle of a post re-arms: the set wins
                    next_st.aer_armed = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Flags for next cycle, taken from the updated pointers
        next_st.fetch_valid = next_st.sq_live && next_st.cq_live && !next_st.sq_err
            && (next_st.sq_head != next_st.sq_tail)
            && (next_st.cq_head != ring_inc(next_st.cq_tail, next_st.cq_size));
        next_st.cpl_ready = next_st.cq_live
            && (next_st.cq_head != ring_inc(next_st.cq_tail, next_st.cq_size));
        if (!WRR_URGENT) begin
            next_st.prio = hqr_pkg::RST_PRIO;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
            st.sq_size <= hqr_pkg::RST_SIZE;
            st.cq_size <= hqr_pkg::RST_SIZE;
            st.sq_id <= hqr_pkg::RST_QID;
            st.cq_id <= hqr_pkg::RST_QID;
            st.prio <= hqr_pkg::RST_PRIO;
            st.cq_phase <= hqr_pkg::RST_PHASE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    always_comb begin
        wb_ack = st.ack;
        wb_dat_r = st.rdata;
        sq_fetch_valid = st.fetch_valid;
        sq_fetch_slot = st.sq_head;
        cpl_ready = st.cpl_ready;
        cq_post = st.post;
        aer_post = st.aer;
        sq_priority = st.prio;
    end
endmodule

/* File: include/hqr_pkg.sv */
package hqr_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_QUEUE_CFG = 8'h00;
    localparam logic [7:0] OFS_SQ_SIZE = 8'h04;
    localparam logic [7:0] OFS_CQ_SIZE = 8'h08;
    localparam logic [7:0] OFS_QUEUE_ID = 8'h0C;
    localparam logic [7:0] OFS_SQ_PRIO = 8'h10;
    localparam logic [7:0] OFS_SQ_TAIL_DB = 8'h14;
    localparam logic [7:0] OFS_CQ_HEAD_DB = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_SQ_HEAD = 8'h20;
    localparam logic [7:0] OFS_CAP = 8'h24;
    localparam logic [7:0] OFS_AER_ARM = 8'h28;

    // Field positions
    localparam int CFG_CQ_LIVE = 0;
    localparam int CFG_SQ_LIVE = 1;
    localparam int QID_CQ_LSB = 16;
    localparam int ST_SQ_EMPTY = 0;
    localparam int ST_SQ_FULL = 1;
    localparam int ST_CQ_EMPTY = 2;
    localparam int ST_CQ_FULL = 3;
    localparam int ST_SQ_DB_ERR = 4;
    localparam int ST_CQ_DB_ERR = 5;
    localparam int ST_AER_ARMED = 6;
    localparam int ST_CFG_ERR = 7;
    localparam int ST_SQ_LIVE = 8;
    localparam int ST_CQ_LIVE = 9;

    // Reset values
    localparam logic [15:0] RST_SIZE = 16'h0001;
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [15:0] RST_QID = 16'h0000;
    localparam logic [1:0] RST_PRIO = 2'h0;
    localparam logic RST_PHASE = 1'b1;

    // Queue limits, zero based
    localparam logic [15:0] MIN_SIZE = 16'h0001;
    localparam logic [15:0] IO_MAX_SIZE = 16'hFFFF;
    localparam logic [15:0] ADMIN_MAX_SIZE = 16'h0FFF;
    localparam logic [15:0] ADMIN_QID = 16'h0000;
    localparam logic [7:0] STATUS_INVALID_DB = 8'h01;

    typedef struct packed {
        logic valid;
        logic [15:0] slot;
        logic phase;
        logic [15:0] sq_head_report_field;
        logic [15:0] sq_id;
    } hqr_cpl_post_s;

    typedef struct packed {
        logic valid;
        logic [7:0] status;
        logic [15:0] qid;
    } hqr_aer_post_s;
endpackage

/* File: testbench/hqr_host_model.sv */
`timescale 1ns/100ps
module hqr_host_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic stall,
    input wire logic sq_fetch_valid,
    input wire hqr_pkg::hqr_cpl_post_s cq_post,
    output logic sq_fetch_ack,
    output int post_cnt,
    output int phase_err
);
    // Host clears ring memory to phase 0 before creating the ring; rings stay within 16 slots
    logic [15:0] phase_mem;
    always @(posedge mclk) begin
        if (reset) begin
            sq_fetch_ack <= 1'b0;
            post_cnt <= 0;
            phase_err <= 0;
            phase_mem <= 16'h0000;
        end else begin
            // Stall models a slow consumer; acks only what the ring offers
            // Submitted slots are never rewritten before their fetch
            sq_fetch_ack <= sq_fetch_valid && !stall;
            if (cq_post.valid === 1'b1) begin
                // An entry whose phase did not flip is not seen as new
                if (cq_post.phase === phase_mem[cq_post.slot[3:0]]) begin
                    phase_err <= phase_err + 1;
                end else begin
                    post_cnt <= post_cnt + 1;
                end
                phase_mem[cq_post.slot[3:0]] <= cq_post.phase;
            end
        end
    end
endmodule

/* File: testbench/hqr_queue_pair_bench.sv */
`timescale 1ns/100ps
module hqr_queue_pair_bench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h0000_0000;
    logic stall = 1'b1;
    logic cpl_valid = 1'b0;
    logic [31:0] wb_dat_r, rd;
    logic wb_ack, sq_fetch_valid, sq_fetch_ack, cpl_ready;
    logic [15:0] sq_fetch_slot;
    logic [1:0] sq_priority;
    hqr_pkg::hqr_cpl_post_s cq_post, cpl_last;
    hqr_pkg::hqr_aer_post_s aer_post, aer_last;
    int error_cnt = 0, total_checks = 0, aer_cnt = 0, post_cnt, phase_err;

    always #25 mclk = ~mclk;

    hqr_queue_pair #(.MAX_ENTRIES(16'hFFFF), .WRR_URGENT(1'b0)) DUT (.mclk(mclk),
        .reset(reset), .ce(1'b1), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(4'hF), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .sq_fetch_valid(sq_fetch_valid), .sq_fetch_slot(sq_fetch_slot),
        .sq_fetch_ack(sq_fetch_ack), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready),
        .cq_post(cq_post), .aer_post(aer_post), .sq_priority(sq_priority));
    hqr_host_model u_host (.mclk(mclk), .reset(reset), .stall(stall),
        .sq_fetch_valid(sq_fetch_valid), .cq_post(cq_post), .sq_fetch_ack(sq_fetch_ack),
        .post_cnt(post_cnt), .phase_err(phase_err));

    // Event pulses last one cycle, so they are latched here
    always @(posedge mclk) begin
        if (aer_post.valid === 1'b1) begin
            aer_cnt <= aer_cnt + 1;
            aer_last <= aer_post;
        end
        if (cq_post.valid === 1'b1) begin
            cpl_last <= cq_post;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 40) chk(32'h0000_0000, 32'h0000_0001, "ack timeout");
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string msg);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e, msg);
    endtask

    task automatic wait_low(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
    endtask

    task automatic t_reset_vals;
        rchk(hqr_pkg::OFS_SQ_SIZE, 32'h0000_FFFF, 32'h0000_0001, "sq size");
        rchk(hqr_pkg::OFS_CAP, 32'h0000_FFFF, 32'h0000_FFFF, "cap");
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_03FF, 32'h0000_0005, "status");
        rchk(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    endtask

    task automatic t_create;
        wb(1'b1, hqr_pkg::OFS_QUEUE_ID, 32'h0002_0005);
        wb(1'b1, hqr_pkg::OFS_CQ_SIZE, 32'h0000_0003);
        wb(1'b1, hqr_pkg::OFS_SQ_SIZE, 32'h0000_0003);
        wb(1'b1, hqr_pkg::OFS_QUEUE_CFG, 32'h0000_0002);
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_0380, 32'h0000_0080, "sq before cq");
        wb(1'b1, hqr_pkg::OFS_QUEUE_CFG, 32'h0000_0001);
        wb(1'b1, hqr_pkg::OFS_QUEUE_CFG, 32'h0000_0003);
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_0380, 32'h0000_0300, "both live");
        rchk(hqr_pkg::OFS_QUEUE_ID, 32'hFFFF_FFFF, 32'h0002_0005, "ids");
        wb(1'b1, hqr_pkg::OFS_SQ_PRIO, 32'h0000_0003);
        chk(sq_priority, 32'h0000_0000, "priority");
    endtask

    task automatic t_submit;
        wb(1'b1, hqr_pkg::OFS_SQ_TAIL_DB, 32'h0000_0003);
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0002, "sq full");
        chk({sq_fetch_valid, sq_fetch_slot}, 32'h0001_0000, "head offered");
        stall <= 1'b0;
        wait_low(sq_fetch_valid);
        chk(sq_fetch_slot, 32'h0000_0003, "three taken");
        // Tail moves 3 to 1 across the end: two entries in one write
        wb(1'b1, hqr_pkg::OFS_SQ_TAIL_DB, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        wait_low(sq_fetch_valid);
        chk(sq_fetch_slot, 32'h0000_0001, "wrapped head");
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0001, "sq empty");
        rchk(hqr_pkg::OFS_SQ_HEAD, 32'h0000_FFFF, 32'h0000_0001, "head");
    endtask

    task automatic t_sq_bad;
        wb(1'b1, hqr_pkg::OFS_AER_ARM, 32'h0000_0001);
        wb(1'b1, hqr_pkg::OFS_SQ_TAIL_DB, 32'h0000_0004);
        repeat (2) @(posedge mclk);
        chk(aer_cnt, 32'h0000_0001, "event posted");
        chk({aer_last.status, aer_last.qid}, 32'h0001_0005, "event content");
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_0050, 32'h0000_0010, "sq error");
        wb(1'b1, hqr_pkg::OFS_SQ_TAIL_DB, 32'h0000_0002);
        repeat (3) @(posedge mclk);
        chk({sq_fetch_valid, sq_fetch_slot}, 32'h0000_0001, "no fetch");
    endtask

    task automatic t_complete;
        cpl_valid <= 1'b1;
        wait_low(cpl_ready);
        repeat (4) @(posedge mclk);
        chk(post_cnt, 32'h0000_0003, "posts until full");
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_000C, 32'h0000_0008, "cq full");
        wb(1'b1, hqr_pkg::OFS_CQ_HEAD_DB, 32'h0000_0002);
        repeat (2) @(posedge mclk);
        wait_low(cpl_ready);
        repeat (4) @(posedge mclk);
        cpl_valid <= 1'b0;
        chk(post_cnt, 32'h0000_0005, "two freed");
        chk(phase_err, 32'h0000_0000, "phase flips");
        chk({cpl_last.slot, cpl_last.phase}, 32'h0000_0000, "last slot");
        chk({cpl_last.sq_id, cpl_last.sq_head_report_field}, 32'h0005_0001, "post ids");
        // A head past the size is out of range whatever the ring holds
        wb(1'b1, hqr_pkg::OFS_CQ_HEAD_DB, 32'h0000_0005);
        rchk(hqr_pkg::OFS_STATUS, 32'h0000_0020, 32'h0000_0020, "cq error");
        chk(aer_cnt, 32'h0000_0001, "disarmed");
    endtask

    task automatic results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        t_reset_vals();
        t_create();
        t_submit();
        t_sq_bad();
        t_complete();
        results();
    end

    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        results();
    end
endmodule

/* File: testbench/hqr_queue_pair_chk.sv */
`timescale 1ns/100ps
module hqr_queue_pair_chk #(
    parameter bit WRR_URGENT = 1'b0
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic wb_ack,
    input wire logic sq_fetch_valid,
    input wire logic [15:0] sq_fetch_slot,
    input wire logic sq_fetch_ack,
    input wire logic cpl_valid,
    input wire logic cpl_ready,
    input wire hqr_pkg::hqr_cpl_post_s cq_post,
    input wire hqr_pkg::hqr_aer_post_s aer_post,
    input wire logic [1:0] sq_priority
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_ack_resp; wb_cyc && wb_stb && !wb_ack && ce |=> wb_ack; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
    property p_ack_pulse; wb_ack && ce |=> !wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
    // Checker does not know the size, so a move to slot 0 is accepted as a wrap
    property p_fetch_adv; sq_fetch_valid && sq_fetch_ack && ce |=>
        (sq_fetch_slot == $past(sq_fetch_slot) + 16'h0001) || (sq_fetch_slot == 16'h0000);
    endproperty
    a_fetch_adv: assert property (p_fetch_adv) else $error("head did not advance");
    property p_post_resp; cpl_valid && cpl_ready && ce |=> cq_post.valid; endproperty
    a_post_resp: assert property (p_post_resp) else $error("taken completion not posted");
    property p_post_cause; cq_post.valid |-> $past(cpl_valid && cpl_ready); endproperty
    a_post_cause: assert property (p_post_cause) else $error("post without take");
    property p_sq_head_report_field; cq_post.valid |-> cq_post.sq_head_report_field == sq_fetch_slot; endproperty
    a_sq_head_report_field: assert property (p_sq_head_report_field) else $error("reported head differs");
    property p_prio; !WRR_URGENT |-> sq_priority == 2'h0; endproperty
    a_prio: assert property (p_prio) else $error("priority not ignored");
    property p_aer_cause; aer_post.valid |-> aer_post.status == hqr_pkg::STATUS_INVALID_DB &&
        $past(wb_cyc && wb_stb && wb_we) && ($past(wb_adr) == hqr_pkg::OFS_SQ_TAIL_DB ||
        $past(wb_adr) == hqr_pkg::OFS_CQ_HEAD_DB);
    endproperty
    a_aer_cause: assert property (p_aer_cause) else $error("event without doorbell");
    c_cq_full: cover property (cpl_valid && !cpl_ready);
    c_wrap: cover property (sq_fetch_valid && sq_fetch_ack ##1 sq_fetch_slot == 16'h0000);
    c_aer: cover property (aer_post.valid);
endmodule

bind hqr_queue_pair hqr_queue_pair_chk #(.WRR_URGENT(WRR_URGENT)) u_chk (
    .mclk(mclk), .reset(reset), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_ack(wb_ack), .sq_fetch_valid(sq_fetch_valid),
    .sq_fetch_slot(sq_fetch_slot), .sq_fetch_ack(sq_fetch_ack), .cpl_valid(cpl_valid),
    .cpl_ready(cpl_ready), .cq_post(cq_post), .aer_post(aer_post), .sq_priority(sq_priority));
